// ### common/reset_seq_pkg.sv
package reset_seq_pkg;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int unsigned LF_OSC_HZ        = 31000;
   localparam int unsigned POWERUP_TIMER_MS          = 64;
   localparam int unsigned POWERUP_TIMER_TICKS       = (POWERUP_TIMER_MS * LF_OSC_HZ + 999) / 1000;
   localparam int unsigned BOR_FILTER_US    = 100;
   localparam int unsigned BOR_FILTER_TICKS = (BOR_FILTER_US * LF_OSC_HZ + 999999) / 1000000;
   localparam int unsigned OST_PERIODS      = 1024;
   localparam int unsigned TIMER_W          = 16;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam int unsigned ADDR_W           = 2;
   localparam int unsigned DATA_W           = 8;
   localparam logic [1:0]  PCS_ADDR         = 2'h0;
   localparam logic [1:0]  RST_STATUS_ADDR  = 2'h1;
   localparam int unsigned PCS_BOR_BIT      = 0;
   localparam int unsigned PCS_POR_BIT      = 1;
   localparam int unsigned RS_PD_BIT        = 0;
   localparam int unsigned RS_TO_BIT        = 1;
   localparam int unsigned RS_STATE_LSB     = 4;
   localparam logic        POR_FLAG_RESET   = 1'h0;
   localparam logic        BOR_FLAG_RESET   = 1'h1;
   localparam logic        TO_FLAG_RESET    = 1'h1;
   localparam logic        PD_FLAG_RESET    = 1'h1;

   // ****************************************************************
   // Configuration encodings
   // ****************************************************************
   localparam logic        TRIP_LOWEST      = 1'h0;

   typedef enum logic [2:0] {
      OSC_LP  = 3'h0,
      OSC_XT  = 3'h1,
      OSC_HS  = 3'h2,
      OSC_RC  = 3'h3,
      OSC_EC  = 3'h4,
      OSC_INT = 3'h5
   } osc_mode_t;

   typedef enum logic [2:0] {
      ST_BOR_HOLD = 3'h0,
      ST_POWERUP_TIMER     = 3'h1,
      ST_OST      = 3'h3,
      ST_PIN_WAIT = 3'h2,
      ST_RUN      = 3'h6,
      ST_SLEEP    = 3'h7
   } seq_state_t;

   // Crystal modes need the start-up count; the others run at once.
   function automatic logic is_crystal(input osc_mode_t m);
      return (m == OSC_LP) || (m == OSC_XT) || (m == OSC_HS);
   endfunction : is_crystal

endpackage : reset_seq_pkg

// ### common/timer_if.sv
interface timer_if #(parameter int unsigned W = 16);
   logic         start;
   logic         tick;
   logic [W-1:0] limit;
   logic         expired;

   modport owner   (output start, output tick, output limit, input expired);
   modport counter (input start, input tick, input limit, output expired);
endinterface : timer_if

// ### rtl/brownout_reset_sequencer.sv
// Function
// - enable field 11 always on, 10 off in Sleep, 0x off.
// - trip_select picks one of two brown-out trip points.
// - low supply held past filter time causes brown-out reset.
// - low supply during power-up timer returns to hold and restarts timer.
// - after supply recovers, full 64 ms power-up period before continuing.
// - flash erase forces detection on at lowest trip point.
// - power-up timer after power-on pulse, then oscillator start-up count.
// - time-outs ignore the reset pin; late pin release starts at once.
// - crystal modes add 1024-period start-up after power-up, brown-out, wake.
// - other modes use only the power-up timer, none when disabled or on wake.
// - brownout_flag_n cleared by brown-out only; software sets it.
// - brownout_flag_n is meaningless when detection is disabled.
// - poweron_flag_n cleared by power-on only; software writes 1.
// - power-on and brown-out set timeout and powerdown flags to 1.
// - watchdog reset clears timeout; watchdog wake clears both; pin reset while running none.
// - pin reset in Sleep sets timeout, clears powerdown.
// - power-up timer counts 64 ms on slow oscillator, holds reset.
// - powerup_timer_disable_n set disables the power-up timer.
module brownout_reset_sequencer #(
   parameter int unsigned POWERUP_TIMER_TICKS       = reset_seq_pkg::POWERUP_TIMER_TICKS,
   parameter int unsigned OST_PERIODS      = reset_seq_pkg::OST_PERIODS,
   parameter int unsigned BOR_FILTER_TICKS = reset_seq_pkg::BOR_FILTER_TICKS
) (
   input  logic                              clk_sys,
   input  logic                              rst_n,
   input  logic                              lf_osc_in,
   input  logic                              sys_osc_in,
   input  logic                              low_supply_in,
   input  logic                              ext_reset_pin_n,
   input  logic [1:0]                        brownout_enable,
   input  logic                              trip_select,
   input  logic                              powerup_timer_disable_n,
   input  reset_seq_pkg::osc_mode_t          osc_mode,
   input  logic                              flash_erase,
   input  logic                              sleep_req,
   input  logic                              wake_req,
   input  logic                              wdt_reset_req,
   input  logic                              wdt_wake_req,
   input  logic [reset_seq_pkg::ADDR_W-1:0]  reg_addr,
   input  logic [reset_seq_pkg::DATA_W-1:0]  reg_wdata,
   input  logic                              reg_wr,
   input  logic                              reg_rd,
   output logic [reset_seq_pkg::DATA_W-1:0]  reg_rdata,
   output logic                              chip_reset_n,
   output logic                              monitor_enable,
   output logic                              trip_point
);

   // ****************************************************************
   // Parameter checks
   // ****************************************************************
   localparam int unsigned TW = reset_seq_pkg::TIMER_W;

   if (POWERUP_TIMER_TICKS < 1 || POWERUP_TIMER_TICKS >= (1 << TW) || OST_PERIODS < 1 ||
       OST_PERIODS >= (1 << TW) || BOR_FILTER_TICKS < 1 || BOR_FILTER_TICKS > 255) begin : g_chk
      $error("sequencer count parameters out of range");
   end

   // ****************************************************************
   // Synchronisers
   // ****************************************************************
   logic [3:0] meta_q;
   logic [3:0] sync_q;
   logic [1:0] osc_prev_q;
   logic       lf_tick;
   logic       sys_tick;
   logic       low_s;
   logic       pin_s;

   // Pins and the two oscillators are asynchronous; only sync_q is read.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= 4'h4;
         sync_q <= 4'h4;
      end else begin
         meta_q <= {sys_osc_in, ext_reset_pin_n, low_supply_in, lf_osc_in};
         sync_q <= meta_q;
      end
   end

   // Rising edges of the oscillators become single-cycle ticks.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         osc_prev_q <= 2'h0;
      end else begin
         osc_prev_q <= {sync_q[3], sync_q[0]};
      end
   end

   assign lf_tick  = sync_q[0] && !osc_prev_q[0];
   assign sys_tick = sync_q[3] && !osc_prev_q[1];
   assign low_s    = sync_q[1];
   assign pin_s    = sync_q[2];

   // ****************************************************************
   // Brown-out detection
   // ****************************************************************
   reset_seq_pkg::seq_state_t state_q;
   reset_seq_pkg::seq_state_t state_d;
   logic [7:0] filt_q;
   logic       det_active;
   logic       low_det;
   logic       bor_trip;

   // Erase overrides the enable field; 10 drops out only while asleep.
   assign det_active = flash_erase || (brownout_enable[1] &&
                       (brownout_enable[0] || state_q != reset_seq_pkg::ST_SLEEP));
   assign low_det    = det_active && low_s;

   // Filter counts slow-oscillator ticks while the supply stays low.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         filt_q <= 8'h00;
      end else if (!low_det) begin
         filt_q <= 8'h00;
      end else if (lf_tick && filt_q != 8'(BOR_FILTER_TICKS)) begin
         filt_q <= filt_q + 8'h01;
      end
   end

   assign bor_trip = low_det && (filt_q == 8'(BOR_FILTER_TICKS));

   // ****************************************************************
   // Time-out counters
   // ****************************************************************
   timer_if #(.W(TW)) powerup_timer_tmr ();
   timer_if #(.W(TW)) ost_tmr ();

   assign powerup_timer_tmr.tick  = lf_tick;
   assign powerup_timer_tmr.limit = TW'(POWERUP_TIMER_TICKS);
   assign powerup_timer_tmr.start = (state_d == reset_seq_pkg::ST_POWERUP_TIMER) && (state_q != reset_seq_pkg::ST_POWERUP_TIMER);
   assign ost_tmr.tick   = sys_tick;
   assign ost_tmr.limit  = TW'(OST_PERIODS);
   assign ost_tmr.start  = (state_d == reset_seq_pkg::ST_OST) && (state_q != reset_seq_pkg::ST_OST);

   timeout_counter #(.W(TW)) u_powerup_timer (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .tmr     (powerup_timer_tmr)
   );

   timeout_counter #(.W(TW)) u_ost (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .tmr     (ost_tmr)
   );

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   logic bor_enter;
   logic bor_event;
   logic ext_sleep;
   logic crystal;

   // First time-out after a power-on or brown-out hold ends.
   function automatic reset_seq_pkg::seq_state_t first_timeout(input logic ptdn, input logic xtal);
      if (!ptdn) begin
         return reset_seq_pkg::ST_POWERUP_TIMER;
      end else if (xtal) begin
         return reset_seq_pkg::ST_OST;
      end
      return reset_seq_pkg::ST_PIN_WAIT;
   endfunction : first_timeout

   assign crystal = reset_seq_pkg::is_crystal(osc_mode);
   // While the power-up timer runs, a low supply re-enters hold without filtering.
   assign bor_enter = (state_q == reset_seq_pkg::ST_POWERUP_TIMER) ? low_det : bor_trip;
   assign bor_event = bor_enter && (state_q != reset_seq_pkg::ST_BOR_HOLD);
   assign ext_sleep = (state_q == reset_seq_pkg::ST_SLEEP) && !pin_s;

   // Next state; brown-out entry beats every other transition.
   always_comb begin
      state_d = state_q;
      if (bor_event) begin
         state_d = reset_seq_pkg::ST_BOR_HOLD;
      end else begin
         unique case (state_q)
            reset_seq_pkg::ST_BOR_HOLD: begin
               if (!low_det) begin
                  state_d = first_timeout(powerup_timer_disable_n, crystal);
               end
            end
            reset_seq_pkg::ST_POWERUP_TIMER: begin
               if (powerup_timer_tmr.expired) begin
                  state_d = crystal ? reset_seq_pkg::ST_OST : reset_seq_pkg::ST_PIN_WAIT;
               end
            end
            reset_seq_pkg::ST_OST: begin
               if (ost_tmr.expired) begin
                  state_d = reset_seq_pkg::ST_PIN_WAIT;
               end
            end
            reset_seq_pkg::ST_PIN_WAIT: begin
               if (pin_s) begin
                  state_d = reset_seq_pkg::ST_RUN;
               end
            end
            reset_seq_pkg::ST_RUN: begin
               if (!pin_s) begin
                  state_d = reset_seq_pkg::ST_PIN_WAIT;
               end else if (sleep_req) begin
                  state_d = reset_seq_pkg::ST_SLEEP;
               end
            end
            reset_seq_pkg::ST_SLEEP: begin
               if (!pin_s) begin
                  state_d = reset_seq_pkg::ST_PIN_WAIT;
               end else if (wake_req) begin
                  state_d = crystal ? reset_seq_pkg::ST_OST : reset_seq_pkg::ST_RUN;
               end
            end
            default: begin
               state_d = reset_seq_pkg::ST_BOR_HOLD;
            end
         endcase
      end
   end

   // The power-on pulse is the reset itself; hold starts every sequence.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= reset_seq_pkg::ST_BOR_HOLD;
      end else begin
         state_q <= state_d;
      end
   end

   // Internal reset stays low until every enabled time-out and the pin allow it.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         chip_reset_n <= 1'h0;
      end else begin
         chip_reset_n <= (state_d == reset_seq_pkg::ST_RUN) ||
                         (state_d == reset_seq_pkg::ST_SLEEP);
      end
   end

   // Comparator controls: erase forces the lowest trip point.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         monitor_enable <= 1'h0;
         trip_point     <= reset_seq_pkg::TRIP_LOWEST;
      end else begin
         monitor_enable <= det_active;
         trip_point     <= flash_erase ? reset_seq_pkg::TRIP_LOWEST : trip_select;
      end
   end

   // ****************************************************************
   // Status flags and register port
   // ****************************************************************
   logic pcs_wr;
   logic poweron_flag_n_q;
   logic brownout_flag_n_q;
   logic timeout_flag_n_q;
   logic powerdown_flag_n_q;

   assign pcs_wr = reg_wr && (reg_addr == reset_seq_pkg::PCS_ADDR);

   // Hardware clears beat a software write in the same cycle so no event is lost.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         poweron_flag_n_q  <= reset_seq_pkg::POR_FLAG_RESET;
         brownout_flag_n_q <= reset_seq_pkg::BOR_FLAG_RESET;
      end else begin
         if (pcs_wr) begin
            poweron_flag_n_q <= reg_wdata[reset_seq_pkg::PCS_POR_BIT];
         end
         if (bor_event) begin
            brownout_flag_n_q <= 1'h0;
         end else if (pcs_wr) begin
            brownout_flag_n_q <= reg_wdata[reset_seq_pkg::PCS_BOR_BIT];
         end
      end
   end

   // Reset-cause flags; a pin reset while running touches nothing.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         timeout_flag_n_q   <= reset_seq_pkg::TO_FLAG_RESET;
         powerdown_flag_n_q <= reset_seq_pkg::PD_FLAG_RESET;
      end else if (bor_event) begin
         timeout_flag_n_q   <= 1'h1;
         powerdown_flag_n_q <= 1'h1;
      end else if (wdt_wake_req) begin
         timeout_flag_n_q   <= 1'h0;
         powerdown_flag_n_q <= 1'h0;
      end else if (wdt_reset_req) begin
         timeout_flag_n_q   <= 1'h0;
      end else if (ext_sleep) begin
         timeout_flag_n_q   <= 1'h1;
         powerdown_flag_n_q <= 1'h0;
      end
   end

   // Read data; the brown-out flag is shown but nothing here acts on it.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         reg_rdata <= '0;
         if (reg_addr == reset_seq_pkg::PCS_ADDR) begin
            reg_rdata[reset_seq_pkg::PCS_POR_BIT] <= poweron_flag_n_q;
            reg_rdata[reset_seq_pkg::PCS_BOR_BIT] <= brownout_flag_n_q;
         end else if (reg_addr == reset_seq_pkg::RST_STATUS_ADDR) begin
            reg_rdata[reset_seq_pkg::RS_TO_BIT] <= timeout_flag_n_q;
            reg_rdata[reset_seq_pkg::RS_PD_BIT] <= powerdown_flag_n_q;
            reg_rdata[reset_seq_pkg::RS_STATE_LSB +: 3] <= state_q;
         end
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   // The sampled reset keeps the release edge out: the state is still forced to hold there.
   hold_release_a: assert property (rst_n && state_q == reset_seq_pkg::ST_BOR_HOLD && !low_det
      && !powerup_timer_disable_n |=> state_q == reset_seq_pkg::ST_POWERUP_TIMER ##1 !powerup_timer_tmr.expired)
      else $error("hold did not restart timer");
   powerup_timer_restart_a: assert property (state_q == reset_seq_pkg::ST_POWERUP_TIMER && low_det
      |=> state_q == reset_seq_pkg::ST_BOR_HOLD && !chip_reset_n) else $error("low supply ignored in timer");
   ost_order_a: assert property (state_q == reset_seq_pkg::ST_POWERUP_TIMER && powerup_timer_tmr.expired && crystal
      && !low_det |=> state_q == reset_seq_pkg::ST_OST) else $error("start-up count not after timer");
   no_timeout_a: assert property (rst_n && state_q == reset_seq_pkg::ST_BOR_HOLD && !low_det
      && powerup_timer_disable_n && !crystal |=> state_q == reset_seq_pkg::ST_PIN_WAIT)
      else $error("unexpected time-out");
   pin_release_a: assert property (state_q == reset_seq_pkg::ST_PIN_WAIT && pin_s && !bor_event
      |=> chip_reset_n && state_q == reset_seq_pkg::ST_RUN) else $error("pin release not immediate");
   reset_held_a: assert property (state_q inside {reset_seq_pkg::ST_POWERUP_TIMER, reset_seq_pkg::ST_OST}
      |-> !chip_reset_n) else $error("reset released during time-out");
   bor_flags_a: assert property (bor_event && !pcs_wr |=> !brownout_flag_n_q && timeout_flag_n_q
      && powerdown_flag_n_q && poweron_flag_n_q == $past(poweron_flag_n_q)) else $error("brown-out flags wrong");
   erase_force_a: assert property (flash_erase
      |=> monitor_enable && trip_point == reset_seq_pkg::TRIP_LOWEST) else $error("erase did not force detection");
   wdt_wake_a: assert property (wdt_wake_req && !bor_event |=> !timeout_flag_n_q && !powerdown_flag_n_q)
      else $error("watchdog wake flags wrong");
   sleep_pin_a: assert property (ext_sleep && !bor_event && !wdt_wake_req && !wdt_reset_req
      |=> timeout_flag_n_q && !powerdown_flag_n_q) else $error("sleep pin reset flags wrong");
   mode_off_a: assert property (!brownout_enable[1] && !flash_erase |=> !monitor_enable)
      else $error("detection on while disabled");
   glitch_filter_a: assert property (!low_s && state_q != reset_seq_pkg::ST_BOR_HOLD
      |=> state_q != reset_seq_pkg::ST_BOR_HOLD) else $error("brown-out without filtered low");

   run_reached_c: cover property (state_q == reset_seq_pkg::ST_PIN_WAIT ##1 state_q == reset_seq_pkg::ST_RUN);
   powerup_timer_restart_c: cover property (state_q == reset_seq_pkg::ST_POWERUP_TIMER ##1 state_q == reset_seq_pkg::ST_BOR_HOLD);
   ost_done_c: cover property (state_q == reset_seq_pkg::ST_OST && ost_tmr.expired);
   sleep_wake_c: cover property (state_q == reset_seq_pkg::ST_SLEEP && wake_req && pin_s);

endmodule : brownout_reset_sequencer

// ### rtl/timeout_counter.sv
module timeout_counter #(
   parameter int unsigned W = 16
) (
   input  logic     clk_sys,
   input  logic     rst_n,
   timer_if.counter tmr
);

   logic [W-1:0] count_q;
   logic         expired_q;

   if (W < 2) begin : g_chk
      $error("timeout_counter needs at least two bits");
   end

   // Count ticks from a start pulse; a new start always wins.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= '0;
      end else if (tmr.start) begin
         count_q <= '0;
      end else if (tmr.tick && !expired_q) begin
         count_q <= count_q + W'(1);
      end
   end

   // Expiry is a level held until the next start.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         expired_q <= 1'h0;
      end else if (tmr.start) begin
         expired_q <= 1'h0;
      end else if (tmr.tick && (count_q == tmr.limit - W'(1))) begin
         expired_q <= 1'h1;
      end
   end

   assign tmr.expired = expired_q;

endmodule : timeout_counter

// ### verification/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // Short counts keep each power-up below a few hundred cycles.
   localparam int unsigned PT = 8;
   localparam int unsigned OP = 4;
   localparam int unsigned BF = 2;
   logic clk_sys = 1'b0, rst_n = 1'b0, lf_osc_in = 1'b0, sys_osc_in = 1'b0, low_supply_in = 1'b0;
   logic ext_reset_pin_n = 1'b1, trip_select = 1'b0, powerup_timer_disable_n = 1'b0, flash_erase = 1'b0;
   logic sleep_req = 1'b0, wake_req = 1'b0, wdt_reset_req = 1'b0, wdt_wake_req = 1'b0;
   logic reg_wr = 1'b0, reg_rd = 1'b0, rd_seen = 1'b0;
   logic [1:0] brownout_enable = 2'h0, reg_addr = 2'h0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, div_q = 8'h00, exp_q[$], msk_q[$];
   logic chip_reset_n, monitor_enable, trip_point;
   reset_seq_pkg::osc_mode_t osc_mode = reset_seq_pkg::OSC_XT;
   int error_cnt = 0, n_checks = 0, c;

   brownout_reset_sequencer #(.POWERUP_TIMER_TICKS(PT), .OST_PERIODS(OP), .BOR_FILTER_TICKS(BF)) dut (
      .clk_sys(clk_sys), .rst_n(rst_n), .lf_osc_in(lf_osc_in), .sys_osc_in(sys_osc_in),
      .low_supply_in(low_supply_in), .ext_reset_pin_n(ext_reset_pin_n), .brownout_enable(brownout_enable),
      .trip_select(trip_select), .powerup_timer_disable_n(powerup_timer_disable_n), .osc_mode(osc_mode),
      .flash_erase(flash_erase), .sleep_req(sleep_req), .wake_req(wake_req), .wdt_reset_req(wdt_reset_req),
      .wdt_wake_req(wdt_wake_req), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chip_reset_n(chip_reset_n),
      .monitor_enable(monitor_enable), .trip_point(trip_point));

   // Clock of 50 ns period.
   always #25 clk_sys = ~clk_sys;

   // Slow oscillator is 8 cycles a period, system oscillator 4, both made on the clock edge.
   always @(posedge clk_sys) begin
      div_q      <= div_q + 8'h01;
      lf_osc_in  <= div_q[2];
      sys_osc_in <= div_q[1];
   end

   // Read data load at the edge that samples the strobe and hold until the next read; they are judged one edge later.
   always @(posedge clk_sys) begin
      rd_seen <= reg_rd;
      if (rd_seen) check(reg_rdata & msk_q.pop_front(), exp_q.pop_front());
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : tick

   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [1:0] a, input logic [7:0] exp, input logic [7:0] msk);
      exp_q.push_back(exp);
      msk_q.push_back(msk);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
   endtask : rd

   // Counts cycles until the internal reset reaches the level; a bounded wait.
   task automatic wait_out(input logic lvl, output int cyc);
      cyc = 0;
      while (chip_reset_n !== lvl && cyc < 400) begin
         @(negedge clk_sys);
         cyc++;
      end
   endtask : wait_out

   // Sorts a release time: 0 at once, 1 start-up count only, 2 power-up timer, FF a stall.
   // A stalled wait must never pass for a long power-up timer.
   function automatic logic [7:0] cat(input int n);
      return (n <= 8) ? 8'h00 : ((n < 50) ? 8'h01 : ((n < 150) ? 8'h02 : 8'hFF));
   endfunction : cat

   task automatic power_up(input int m, input logic dis);
      @(posedge clk_sys);
      osc_mode                <= reset_seq_pkg::osc_mode_t'(m);
      powerup_timer_disable_n <= dis;
      rst_n                   <= 1'b0;
      tick(10);
      rst_n <= 1'b1;
      wait_out(1'b1, c);
   endtask : power_up

   task automatic give_verdict;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : give_verdict

   // A hang is cut short well beyond the expected run of about a thousand cycles.
   initial begin
      repeat (20000) @(posedge clk_sys);
      error_cnt++;
      give_verdict();
   end

   // Main sequence.
   initial begin
      void'($urandom(95158));
      for (int m = 0; m < 6; m++) begin
         for (int d = 0; d < 2; d++) begin
            power_up(m, d[0]);
            check(cat(c), d[0] ? ((m < 3) ? 8'h01 : 8'h00) : 8'h02);
         end
      end
      rd(2'h0, 8'h01, 8'hFF);
      rd(2'h1, 8'h03, 8'h03);
      wr(2'h0, 8'h03);
      wr(2'h1, 8'h00);
      wr(2'h2, 8'($urandom));
      rd(2'h0, 8'h03, 8'hFF);
      rd(2'h1, 8'h03, 8'h03);
      rd(2'h2, 8'h00, 8'hFF);
      @(posedge clk_sys);
      brownout_enable         <= 2'h3;
      trip_select             <= 1'b1;
      powerup_timer_disable_n <= 1'b0;
      tick(4);
      @(negedge clk_sys);
      check({6'h00, monitor_enable, trip_point}, 8'h03);
      @(posedge clk_sys);
      low_supply_in <= 1'b1;
      wait_out(1'b0, c);
      check({7'h00, c > 8 && c < 40}, 8'h01);
      @(posedge clk_sys);
      low_supply_in <= 1'b0;
      tick(20);
      low_supply_in <= 1'b1;
      tick(3);
      low_supply_in <= 1'b0;
      wait_out(1'b1, c);
      check(cat(c), 8'h02);
      rd(2'h0, 8'h02, 8'hFF);
      rd(2'h1, 8'h03, 8'h03);
      wdt_reset_req <= 1'b1;
      @(posedge clk_sys);
      wdt_reset_req <= 1'b0;
      rd(2'h1, 8'h01, 8'h03);
      wdt_wake_req <= 1'b1;
      @(posedge clk_sys);
      wdt_wake_req    <= 1'b0;
      ext_reset_pin_n <= 1'b0;
      tick(30);
      ext_reset_pin_n <= 1'b1;
      wait_out(1'b1, c);
      check(cat(c), 8'h00);
      rd(2'h0, 8'h02, 8'hFF);
      rd(2'h1, 8'h00, 8'h03);
      brownout_enable <= 2'h2;
      sleep_req       <= 1'b1;
      @(posedge clk_sys);
      sleep_req <= 1'b0;
      tick(4);
      @(negedge clk_sys);
      check({7'h00, monitor_enable}, 8'h00);
      @(posedge clk_sys);
      flash_erase <= 1'b1;
      tick(4);
      @(negedge clk_sys);
      check({6'h00, monitor_enable, trip_point}, 8'h02);
      @(posedge clk_sys);
      flash_erase     <= 1'b0;
      ext_reset_pin_n <= 1'b0;
      tick(6);
      rd(2'h1, 8'h02, 8'h03);
      ext_reset_pin_n <= 1'b1;
      wait_out(1'b1, c);
      check(cat(c), 8'h00);
      // Wake from Sleep: straight to run without a crystal, through the start-up count with one.
      @(posedge clk_sys);
      sleep_req <= 1'b1;
      @(posedge clk_sys);
      sleep_req <= 1'b0;
      wake_req  <= 1'b1;
      @(posedge clk_sys);
      wake_req <= 1'b0;
      rd(2'h1, 8'h60, 8'h70);
      osc_mode  <= reset_seq_pkg::OSC_XT;
      sleep_req <= 1'b1;
      @(posedge clk_sys);
      sleep_req <= 1'b0;
      wake_req  <= 1'b1;
      @(posedge clk_sys);
      wake_req <= 1'b0;
      wait_out(1'b0, c);
      wait_out(1'b1, c);
      check(cat(c), 8'h01);
      @(posedge clk_sys);
      brownout_enable <= 2'h0;
      low_supply_in   <= 1'b1;
      tick(60);
      @(negedge clk_sys);
      check({6'h00, monitor_enable, chip_reset_n}, 8'h01);
      @(posedge clk_sys);
      low_supply_in <= 1'b0;
      tick(3);
      give_verdict();
   end
endmodule : tb_top
